//--- hw/csco_pkg.sv
package csco_pkg;
   // ----------------------------------------------------------------
   // object indices (sub-index 0 only)
   // ----------------------------------------------------------------
   localparam logic [15:0] IDX_DEVICE_KIND = 16'h1000;
   localparam logic [15:0] IDX_FAULT_SUMMARY = 16'h1001;
   localparam logic [15:0] IDX_SYNC_FRAME = 16'h1005;
   localparam logic [15:0] IDX_SYNC_PERIOD = 16'h1006;
   localparam logic [7:0] SUB_ZERO = 8'h00;
   // ----------------------------------------------------------------
   // field layout of the device kind object
   // ----------------------------------------------------------------
   localparam int KIND_MODE_LSB = 24;
   localparam int KIND_TYPE_LSB = 16;
   localparam int KIND_PROFILE_LSB = 0;
   localparam logic [7:0] KIND_MODE_BITS = 8'h00;
   // ----------------------------------------------------------------
   // field layout and reset of the sync frame object, reset of the sync period and fault summary
   // ----------------------------------------------------------------
   localparam int SYNC_GEN_BIT = 30;
   localparam int SYNC_EXT_BIT = 29;
   localparam int SYNC_ID_MSB = 10;
   localparam logic [31:0] SYNC_FRAME_RESET = 32'h0000_0080;
   localparam logic [31:0] SYNC_PERIOD_RESET = 32'h0000_0000;
   localparam logic [7:0] FAULT_RESET = 8'h00;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 125_000_000;
   localparam int TICK_US = 1;
   localparam int US_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
   localparam logic [31:0] US_PER_MS = 32'h0000_03e8;
   localparam logic [3:0] MEAS_GAPS = 4'ha;
   // ----------------------------------------------------------------
   // interval monitor states, gray along idle, measure, run
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MON_IDLE = 2'b00,
      MON_MEAS = 2'b01,
      MON_RUN = 2'b11
   } csco_mon_type;
endpackage

//--- hw/csco_sync_mon.sv
`timescale 1ns/1ps
module csco_sync_mon (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic usTick,
   input wire logic syncRx,
   input wire logic syncEnable,
   input wire logic [31:0] period,
   output logic commErr,
   output logic measDone,
   output logic [31:0] measInterval
);
   import csco_pkg::*;

   typedef struct packed {
      csco_mon_type st;
      logic [31:0] gapUs;
      logic [3:0] gaps;
      logic [35:0] sum;
      logic fired;
      logic err;
      logic done;
      logic [31:0] meas;
   } csco_mon_state_type;

   csco_mon_state_type s_q, s_d;
   logic [32:0] limitUs;

   // allowed gap is the period plus half of it
   assign limitUs = {1'b0, period} + {2'b00, period[31:1]};

   // ----------------------------------------------------------------
   // gap counting, measurement and overrun watch
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.err = 1'b0;
      if (usTick && s_q.gapUs != 32'hffff_ffff) begin
         s_d.gapUs = s_q.gapUs + 32'h1;
      end
      if (!syncEnable) begin
         // frames ignored until a synchronous pdo is live
         s_d.st = MON_IDLE;
         s_d.fired = 1'b0;
      end else if (syncRx) begin
         // every received frame restarts the overrun timer
         s_d.gapUs = 32'h0;
         s_d.fired = 1'b0;
         case (s_q.st)
            MON_IDLE: begin
               s_d.st = (period == 32'h0 && !s_q.done) ? MON_MEAS : MON_RUN;
               s_d.gaps = 4'h0;
               s_d.sum = 36'h0;
            end
            MON_MEAS: begin
               // eleven frames give ten gaps, averaged into measInterval
               // a tick landing on the frame edge still belongs to the gap it closes,
               // otherwise the mean drops by one when ticks and frames share a phase
               s_d.sum = s_q.sum + {4'h0, s_q.gapUs} + {35'h0, usTick};
               s_d.gaps = s_q.gaps + 4'h1;
               if (s_q.gaps + 4'h1 == MEAS_GAPS) begin
                  s_d.meas = 32'((s_q.sum + {4'h0, s_q.gapUs} + {35'h0, usTick}) / 36'd10);
                  s_d.done = 1'b1;
                  s_d.st = MON_RUN;
               end
            end
            MON_RUN: s_d.st = MON_RUN;
            default: s_d.st = MON_IDLE;
         endcase
      end else if (s_q.st == MON_RUN && period != 32'h0 && !s_q.fired
                   && {1'b0, s_q.gapUs} > limitUs) begin
         // one event per missed interval; zero period never watches
         s_d.err = 1'b1;
         s_d.fired = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign commErr = s_q.err;
   assign measDone = s_q.done;
   assign measInterval = s_q.meas;

   chk_err_needs_period: assert property (@(posedge clk) disable iff (!reset_n)
      commErr |-> $past(period) != 32'h0) else $error("event with zero period");
   chk_err_after_limit: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(s_q.err) |-> {1'b0, $past(s_q.gapUs)} > $past(limitUs))
      else $error("event before limit passed");
   chk_err_once: assert property (@(posedge clk) disable iff (!reset_n)
      commErr |=> !commErr) else $error("event repeated in one interval");
   chk_sync_restart: assert property (@(posedge clk) disable iff (!reset_n)
      syncRx && syncEnable |=> s_q.gapUs == 32'h0 && !s_q.fired)
      else $error("timer not restarted");
   chk_meas_count: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(measDone) |-> $past(s_q.gaps) == 4'h9 && $past(syncRx))
      else $error("measure not on eleventh frame");
   chk_pdo_gate: assert property (@(posedge clk) disable iff (!reset_n)
      !syncEnable |=> s_q.st == MON_IDLE) else $error("sync without pdo");
endmodule

//--- hw/csco_top.sv
`timescale 1ns/1ps
module csco_top #(
   parameter logic [15:0] PROFILE_CODE = 16'h0a5a, // arbitrary value
   parameter logic [7:0] SERVO_CLASS = 8'h11, // arbitrary value
   parameter logic [7:0] FREQ_CLASS = 8'h22 // arbitrary value
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic objReq,
   input wire logic objWrite,
   input wire logic [15:0] objIndex,
   input wire logic [7:0] objSub,
   input wire logic [31:0] objWrFrame,
   output logic objAck,
   output logic objAbort,
   output logic [31:0] objRdFrame,
   input wire logic firmwareNew,
   input wire logic [15:0] configSel,
   input wire logic [7:0] faultBits,
   input wire logic syncRx,
   input wire logic syncPdoActive,
   output logic syncGenEnable,
   output logic syncTxReq,
   output logic [10:0] syncIdent,
   output logic commErr,
   output logic measDone,
   output logic [31:0] measInterval
);
   import csco_pkg::*;

   typedef struct packed {
      logic [31:0] syncFrame;
      logic [31:0] period;
      logic ack;
      logic abort;
      logic [31:0] rdFrame;
      logic [6:0] usCnt;
      logic usTick;
      logic [31:0] genUs;
      logic txReq;
   } csco_top_state_type;

   csco_top_state_type s_q, s_d;
   logic [7:0] kindType;
   logic [31:0] deviceKind;
   logic [31:0] wrValue;
   logic [31:0] rdValue;
   logic hit;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // frame byte 0 sits in bits 31:24; the value's low byte goes there
   function automatic logic [31:0] swapBytes(input logic [31:0] v);
      swapBytes = {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction

   // any configuration ending in 40 is a motion configuration
   function automatic logic isMotion(input logic [15:0] cfg);
      isMotion = (cfg % 16'd100) == 16'd40;
   endfunction

   // ----------------------------------------------------------------
   // read-only objects
   // ----------------------------------------------------------------
   // type follows configuration only on older firmware
   assign kindType = (firmwareNew || isMotion(configSel)) ? SERVO_CLASS : FREQ_CLASS;
   assign deviceKind = ({24'h0, KIND_MODE_BITS} << KIND_MODE_LSB)
                     | ({24'h0, kindType} << KIND_TYPE_LSB)
                     | ({16'h0, PROFILE_CODE} << KIND_PROFILE_LSB);
   assign wrValue = swapBytes(objWrFrame);
   assign hit = objSub == SUB_ZERO;

   // read mux for the four objects
   always_comb begin
      rdValue = 32'h0;
      case (objIndex)
         IDX_DEVICE_KIND: rdValue = deviceKind;
         IDX_FAULT_SUMMARY: rdValue = {24'h0, faultBits};
         IDX_SYNC_FRAME: rdValue = s_q.syncFrame;
         IDX_SYNC_PERIOD: rdValue = s_q.period;
         default: rdValue = 32'h0;
      endcase
   end

   // ----------------------------------------------------------------
   // object access, timebase and sync generation
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.ack = objReq;
      s_d.abort = 1'b0;
      s_d.usTick = 1'b0;
      s_d.txReq = 1'b0;
      if (objReq) begin
         s_d.rdFrame = 32'h0;
         if (!hit) begin
            s_d.abort = 1'b1;
         end else if (!objWrite) begin
            s_d.rdFrame = swapBytes(rdValue);
            s_d.abort = !(objIndex == IDX_DEVICE_KIND || objIndex == IDX_FAULT_SUMMARY
                          || objIndex == IDX_SYNC_FRAME || objIndex == IDX_SYNC_PERIOD);
         end else if (objIndex == IDX_SYNC_FRAME) begin
            // extended format and the unused 28..11 field are refused
            if (wrValue[SYNC_EXT_BIT] || wrValue[28:11] != 18'h0) begin
               s_d.abort = 1'b1;
            end else begin
               s_d.syncFrame = wrValue;
            end
         end else if (objIndex == IDX_SYNC_PERIOD) begin
            // the sync grid is whole milliseconds, so others are refused
            if (wrValue % US_PER_MS != 32'h0) begin
               s_d.abort = 1'b1;
            end else begin
               s_d.period = wrValue;
            end
         end else begin
            s_d.abort = 1'b1;
         end
      end
      // microsecond tick
      if (s_q.usCnt == 7'(US_CYCLES - 1)) begin
         s_d.usCnt = 7'h0;
         s_d.usTick = 1'b1;
      end else begin
         s_d.usCnt = s_q.usCnt + 7'h1;
      end
      // producer side: one frame per period while enabled
      if (!s_q.syncFrame[SYNC_GEN_BIT] || s_q.period == 32'h0) begin
         s_d.genUs = 32'h0;
      end else if (s_q.usTick) begin
         if (s_q.genUs + 32'h1 >= s_q.period) begin
            s_d.genUs = 32'h0;
            s_d.txReq = 1'b1;
         end else begin
            s_d.genUs = s_q.genUs + 32'h1;
         end
      end
   end

   // state register; sync frame object comes up as 128, generation off
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_q <= '0;
         s_q.syncFrame <= SYNC_FRAME_RESET;
         s_q.period <= SYNC_PERIOD_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // interval measurement and monitoring
   // ----------------------------------------------------------------
   csco_sync_mon u_mon (
      .clk(clk),
      .reset_n(reset_n),
      .usTick(s_q.usTick),
      .syncRx(syncRx),
      .syncEnable(syncPdoActive),
      .period(s_q.period),
      .commErr(commErr),
      .measDone(measDone),
      .measInterval(measInterval)
   );

   assign objAck = s_q.ack;
   assign objAbort = s_q.abort;
   assign objRdFrame = s_q.rdFrame;
   assign syncGenEnable = s_q.syncFrame[SYNC_GEN_BIT];
   assign syncTxReq = s_q.txReq;
   assign syncIdent = s_q.syncFrame[SYNC_ID_MSB:0];

   chk_ext_refused: assert property (@(posedge clk) disable iff (!reset_n)
      !s_q.syncFrame[SYNC_EXT_BIT]) else $error("extended format stored");
   chk_period_grid: assert property (@(posedge clk) disable iff (!reset_n)
      s_q.period % US_PER_MS == 32'h0) else $error("period off grid");
   chk_read_order: assert property (@(posedge clk) disable iff (!reset_n)
      objReq && !objWrite && hit && objIndex == IDX_FAULT_SUMMARY
      |=> objAck && objRdFrame == {$past(faultBits), 24'h0})
      else $error("fault summary read wrong");
   chk_type_new: assert property (@(posedge clk) disable iff (!reset_n)
      firmwareNew |-> deviceKind[23:16] == SERVO_CLASS) else $error("type wrong");
   chk_no_gen_off: assert property (@(posedge clk) disable iff (!reset_n)
      !syncGenEnable |=> !syncTxReq) else $error("sync sent while off");
endmodule

//--- tb/csco_sync_src.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// sync producer standing in for the network master
// ----------------------------------------------------------------
module csco_sync_src (
   input wire logic clk,
   input wire logic start,
   input wire logic [7:0] count,
   input wire logic [15:0] gap,
   output logic syncRx,
   output logic busy
);
   int left = 0;
   int wait_q = 0;
   initial begin
      syncRx = 1'b0;
      busy = 1'b0;
   end
   // spacing never changes inside a burst, so a finished measurement stays valid
   always @(posedge clk) begin
      syncRx <= 1'b0;
      if (start && !busy) begin
         busy <= 1'b1;
         left <= count;
         wait_q <= 0;
      end else if (busy && wait_q == 0) begin
         syncRx <= 1'b1; // one-cycle frame pulse
         wait_q <= gap - 1;
         left <= left - 1;
         if (left == 1) begin
            busy <= 1'b0;
         end
      end else if (busy) begin
         wait_q <= wait_q - 1;
      end
   end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import csco_pkg::*;
   localparam logic [15:0] PROF = 16'h0c3c; // arbitrary value
   localparam logic [7:0] SERVO = 8'h5a; // arbitrary value
   localparam logic [7:0] FREQ = 8'ha5; // arbitrary value
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic objReq = 1'b0;
   logic objWrite = 1'b0;
   logic [15:0] objIndex = 16'h0000;
   logic [7:0] objSub = 8'h00;
   logic [31:0] objWrFrame = 32'h0000_0000;
   logic firmwareNew = 1'b0;
   logic [15:0] configSel = 16'h0000;
   logic [7:0] faultBits = 8'h00;
   logic syncPdoActive = 1'b0;
   logic srcStart = 1'b0;
   logic [15:0] srcGap = 16'h0000;
   logic objAck, objAbort, syncGenEnable, syncTxReq, commErr, measDone, syncRx, srcBusy;
   logic [31:0] objRdFrame;
   logic [31:0] measInterval;
   logic [10:0] syncIdent;
   logic [31:0] modelSync = SYNC_FRAME_RESET;
   logic [31:0] modelPeriod = SYNC_PERIOD_RESET;
   logic [31:0] periods [5] = '{32'h0fa0, 32'h05dc, 32'h4a38, 32'h0001, 32'h0000};
   logic oddSeen = 1'b0;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   int seed = 17261;

   // ----------------------------------------------------------------
   // clock, design, far side
   // ----------------------------------------------------------------
   always #4 clk = ~clk;
   csco_top #(.PROFILE_CODE(PROF), .SERVO_CLASS(SERVO), .FREQ_CLASS(FREQ)) csco_top_i (
      .clk(clk), .reset_n(reset_n), .objReq(objReq), .objWrite(objWrite),
      .objIndex(objIndex), .objSub(objSub), .objWrFrame(objWrFrame), .objAck(objAck),
      .objAbort(objAbort), .objRdFrame(objRdFrame), .firmwareNew(firmwareNew),
      .configSel(configSel), .faultBits(faultBits), .syncRx(syncRx),
      .syncPdoActive(syncPdoActive), .syncGenEnable(syncGenEnable), .syncTxReq(syncTxReq),
      .syncIdent(syncIdent), .commErr(commErr), .measDone(measDone),
      .measInterval(measInterval));
   csco_sync_src csco_sync_src_i (.clk(clk), .start(srcStart), .count(8'h0b), .gap(srcGap),
      .syncRx(syncRx), .busy(srcBusy));

   // watchdog; also notes any stray event while the period is zero
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (reset_n && (commErr === 1'b1 || syncTxReq === 1'b1)) begin
         oddSeen <= 1'b1;
      end
      if (cycles == 60000) begin
         miscompares++;
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // value order to frame order: least significant byte goes out first
   function automatic logic [31:0] swap(input logic [31:0] v);
      return {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // one object access; expectation is worked out after earlier drives have landed
   task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
         input logic [31:0] val);
      logic abt;
      logic [31:0] rd;
      logic [7:0] kind;
      @(posedge clk);
      kind = (firmwareNew || configSel % 100 == 40) ? SERVO : FREQ;
      abt = 1'b1;
      rd = 32'h0;
      if (sub == SUB_ZERO && !wr) begin
         abt = !(idx inside {IDX_DEVICE_KIND, IDX_FAULT_SUMMARY, IDX_SYNC_FRAME,
            IDX_SYNC_PERIOD});
         rd = idx == IDX_DEVICE_KIND ? {KIND_MODE_BITS, kind, PROF} :
            idx == IDX_FAULT_SUMMARY ? {24'h0, faultBits} :
            idx == IDX_SYNC_FRAME ? modelSync : modelPeriod;
      end
      if (sub == SUB_ZERO && wr && idx == IDX_SYNC_FRAME) abt = val[29] || val[28:11] != 0;
      if (sub == SUB_ZERO && wr && idx == IDX_SYNC_PERIOD) abt = val % 1000 != 0;
      if (abt) rd = 32'h0;
      objReq <= 1'b1;
      objWrite <= wr;
      objIndex <= idx;
      objSub <= sub;
      objWrFrame <= swap(val);
      @(posedge clk);
      objReq <= 1'b0;
      #1;
      check({31'h0, objAck}, 32'h1);
      check({31'h0, objAbort}, {31'h0, abt});
      check(objRdFrame, swap(rd));
      if (wr && !abt && idx == IDX_SYNC_FRAME) modelSync = val;
      if (wr && !abt && idx == IDX_SYNC_PERIOD) modelPeriod = val;
   endtask

   // eleven sync frames ten microseconds apart, bounded wait for the far side
   task automatic burst(input logic pdo);
      int n;
      n = 0;
      @(posedge clk);
      syncPdoActive <= pdo;
      srcGap <= 16'(10 * US_CYCLES);
      srcStart <= 1'b1;
      @(posedge clk);
      srcStart <= 1'b0;
      #1;
      while (srcBusy === 1'b1 && n < 20000) begin
         @(posedge clk);
         #1;
         n++;
      end
      repeat (300) @(posedge clk);
      #1;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      #1;
      check({21'h0, syncIdent}, 32'h80);
      access(1'b0, IDX_SYNC_FRAME, SUB_ZERO, 32'h0);
      access(1'b0, IDX_SYNC_PERIOD, SUB_ZERO, 32'h0);
      // frames without an active synchronous pdo must not start a measurement
      burst(1'b0);
      check({31'h0, measDone}, 32'h0);
      burst(1'b1);
      check({31'h0, measDone}, 32'h1);
      check(measInterval, 32'd10);
      check({31'h0, oddSeen}, 32'h0);
      // device kind over both firmware generations; configs 40, 91, 140, 191
      for (int f = 0; f < 2; f++) begin
         for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            firmwareNew <= f[0];
            configSel <= 16'(c * 50 + 40 + c % 2);
            access(1'b0, IDX_DEVICE_KIND, SUB_ZERO, 32'h0);
         end
      end
      access(1'b1, IDX_DEVICE_KIND, SUB_ZERO, 32'h1234);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         faultBits <= (k == 0) ? 8'h00 : 8'($random(seed));
         access(1'b0, IDX_FAULT_SUMMARY, SUB_ZERO, 32'h0);
      end
      access(1'b1, IDX_FAULT_SUMMARY, SUB_ZERO, 32'h0);
      // identifier writes: generation on and off, extended format refused
      for (int k = 0; k < 4; k++) begin
         access(1'b1, IDX_SYNC_FRAME, SUB_ZERO, {1'b0, k[0], k[1], 18'h0,
            11'($random(seed))});
         access(1'b0, IDX_SYNC_FRAME, SUB_ZERO, 32'h0);
         check({31'h0, syncGenEnable}, {31'h0, modelSync[30]});
         check({21'h0, syncIdent}, {21'h0, modelSync[10:0]});
      end
      access(1'b1, IDX_SYNC_FRAME, SUB_ZERO, 32'h0000_0800);
      access(1'b0, IDX_SYNC_FRAME, 8'h01, 32'h0);
      access(1'b0, 16'h1002, SUB_ZERO, 32'h0);
      // period must be whole milliseconds; zero is legal
      for (int k = 0; k < 5; k++) begin
         access(1'b1, IDX_SYNC_PERIOD, SUB_ZERO, periods[k]);
         access(1'b0, IDX_SYNC_PERIOD, SUB_ZERO, 32'h0);
      end
      close_out();
   end
endmodule
